// [rtl/dss_pkg.sv]
// shared constants and types for the drive state status word block
package dss_pkg;
   // parameter address of the status word on the fieldbus
   localparam logic [15:0] DSS_STATUS_ADDR = 16'h1B04;
   localparam logic [15:0] DSS_STATUS_RESET = 16'h0000;

   // status word field positions
   localparam int DSS_B_READY = 0;
   localparam int DSS_B_SWITCHED_ON = 1;
   localparam int DSS_B_OP_ENABLE = 2;
   localparam int DSS_B_FAULT = 3;
   localparam int DSS_B_VOLT = 4;
   localparam int DSS_B_QSTOP = 5;
   localparam int DSS_B_SW_DISABLE = 6;
   localparam int DSS_B_WARN = 7;
   localparam int DSS_B_HALT = 8;
   localparam int DSS_B_REMOTE = 9;
   localparam int DSS_B_TARGET = 10;
   localparam int DSS_B_RSVD = 11;
   localparam int DSS_B_MODE = 12;
   localparam int DSS_B_XERR = 13;
   localparam int DSS_B_XEND = 14;
   localparam int DSS_B_REFOK = 15;

   // warning minimum hold time
   localparam int DSS_CLK_HZ = 50_000_000;
   localparam int DSS_WARN_HOLD_MS = 100;
   localparam int DSS_WARN_HOLD_CYC =
      (DSS_WARN_HOLD_MS * (DSS_CLK_HZ / 1000));

   // error class that sends the drive to quick stop instead of fault
   localparam logic [2:0] DSS_ERR_CLASS_QS = 3'h1;

   // operating states, one-hot
   typedef enum logic [7:0] {
      DSS_ST_NOT_READY = 8'h01,
      DSS_ST_SW_DIS = 8'h02,
      DSS_ST_READY = 8'h04,
      DSS_ST_SWITCHED_ON = 8'h08,
      DSS_ST_OP_EN = 8'h10,
      DSS_ST_QSTOP = 8'h20,
      DSS_ST_FAULT_REACT = 8'h40,
      DSS_ST_FAULT = 8'h80
   } dss_state_t;

   // state machine commands
   typedef enum logic [2:0] {
      DSS_CMD_SHUTDOWN = 3'h0,
      DSS_CMD_SWITCH_ON = 3'h1,
      DSS_CMD_DIS_VOLT = 3'h2,
      DSS_CMD_QSTOP = 3'h3,
      DSS_CMD_DIS_OP = 3'h4,
      DSS_CMD_EN_OP = 3'h5
   } dss_cmd_t;
endpackage

// [rtl/dss_warn_if.sv]
// carrier between status top and warning hold timer
`timescale 1ns/1ns
interface dss_warn_if;
   logic warn_present;
   logic fault_reset;
   logic warn_bit;

   modport top (
      output warn_present,
      output fault_reset,
      input warn_bit
   );
   modport hold (
      input warn_present,
      input fault_reset,
      output warn_bit
   );
endinterface

// [rtl/dss_warn_hold.sv]
// warning bit with minimum hold time and fault reset override
`timescale 1ns/1ns
module dss_warn_hold #(
   parameter int HOLD_CYC = dss_pkg::DSS_WARN_HOLD_CYC
) (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   dss_warn_if.hold wif
);
   import dss_pkg::*;

   localparam int CW = $clog2(HOLD_CYC + 1);
   localparam logic [CW-1:0] LOAD = CW'(HOLD_CYC - 1);

   logic [CW-1:0] hold_cnt;
   logic warn_q;

   // hold counter restarts whenever the bit is first raised
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         hold_cnt <= '0;
      end else if (wif.fault_reset) begin
         hold_cnt <= '0; // RULE8
      end else if (wif.warn_present && !warn_q) begin
         hold_cnt <= LOAD; // RULE7
      end else if (hold_cnt != '0) begin
         hold_cnt <= hold_cnt - CW'(1);
      end
   end

   // bit follows warning, only a fault reset drops it before the hold runs out
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         warn_q <= 1'b0;
      end else if (wif.fault_reset) begin
         warn_q <= 1'b0; // RULE8
      end else if (wif.warn_present) begin
         warn_q <= 1'b1; // RULE6
      end else if (hold_cnt == '0) begin
         warn_q <= 1'b0; // RULE7
      end
   end

   assign wif.warn_bit = warn_q;
endmodule

// [rtl/dss_status_top.sv]
// drive state machine, status word and state signal outputs
// Functional notes
// RULE1 - no fault high in states 4,5,6; active high only in state 6
// RULE2 - states 2..5 coded in bits 6,5,3,2,1,0 as tabled
// RULE3 - states 6..9 coded in bits 6,5,3,2,1,0 as tabled
// RULE4 - bit 4 set while DC bus voltage is present and correct
// RULE5 - no move from state 3 to 4 without voltage
// RULE6 - bit 7 set while any warning is active; motion goes on
// RULE7 - warning bit holds at least 100 ms once set
// RULE8 - fault reset clears the warning bit at once
// RULE9 - bit 8 shows an active halt request
// RULE10 - bit 9 set when fieldbus commands are accepted
// RULE11 - parameter access works even while remote is clear
// RULE12 - bit 10 rises only after good end and standstill
// RULE13 - bit 10 low while running, after halt or error cancel
// RULE14 - bit 12 carries the operating mode indication
// RULE15 - bit 13 set on error that must be remedied
// RULE16 - bit 14 cleared when an operating mode starts
// RULE17 - bit 14 back to one at standstill after end or halt
// RULE18 - bit 14 stays low when a new mode follows immediately
// RULE19 - bit 15 set while a valid reference point is held
// RULE20 - reference stays valid when the power stage is disabled
// RULE21 - state 8 goes to 9 when error response completes
// RULE22 - fault reset in state 9 returns to 3 if cause cleared
// RULE23 - bit 11 reads zero; status refreshed every clock
`timescale 1ns/1ns
module dss_status_top #(
   parameter int WARN_HOLD_CYC = dss_pkg::DSS_WARN_HOLD_CYC
) (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic dc_bus_ok_i,
   input wire logic init_done_i,
   input wire logic cmd_valid_i,
   input wire dss_pkg::dss_cmd_t cmd_i,
   input wire logic cmd_from_fb_i,
   input wire logic remote_i,
   input wire logic fault_reset_i,
   input wire logic cause_cleared_i,
   input wire logic err_valid_i,
   input wire logic [2:0] err_class_i,
   input wire logic err_resp_done_i,
   input wire logic [15:0] active_warning_register_i,
   input wire logic halt_i,
   input wire logic op_start_i,
   input wire logic op_done_ok_i,
   input wire logic standstill_i,
   input wire logic mode_bit_i,
   input wire logic ref_set_i,
   input wire logic ref_lost_i,
   input wire logic sig_out_cfg_i,
   input wire logic param_rd_i,
   input wire logic param_wr_i,
   input wire logic [15:0] param_addr_i,
   output logic [15:0] param_rdata_o,
   output logic param_ack_o,
   output logic param_err_o,
   output logic [15:0] drive_state_status_word_o,
   output logic no_fault_o,
   output logic active_o
);
   import dss_pkg::*;

   logic rst_meta;
   logic rst_n;
   logic volt_meta;
   logic volt_ok;
   dss_state_t state;
   dss_state_t next_state;
   logic cmd_ok;
   logic err_fault;
   logic err_qstop;
   logic [15:0] next_status;
   logic [15:0] status;
   logic op_running;
   logic op_good;
   logic target;
   logic x_err;
   logic x_end;
   logic ref_ok;
   logic halt_q;
   logic remote_q;
   logic mode_q;

   dss_warn_if wif ();

   // reset released through two flops, asserted at once
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // bus voltage monitor is a pin, synchronised before use
   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         volt_meta <= 1'b0;
         volt_ok <= 1'b0;
      end else begin
         volt_meta <= dc_bus_ok_i;
         volt_ok <= volt_meta;
      end
   end

   // fieldbus commands only count while the fieldbus has control
   assign cmd_ok = cmd_valid_i && (remote_i || !cmd_from_fb_i); // RULE10
   // class 1 ends in quick stop from operation enabled, higher classes in fault reaction
   assign err_qstop = err_valid_i && (err_class_i == DSS_ERR_CLASS_QS);
   assign err_fault = err_valid_i && (err_class_i > DSS_ERR_CLASS_QS);

   // next operating state; errors take priority over commands
   always_comb begin
      next_state = state;
      unique case (state)
         DSS_ST_NOT_READY: begin
            if (init_done_i) begin
               next_state = DSS_ST_SW_DIS;
            end
         end
         DSS_ST_SW_DIS: begin
            if (cmd_ok && cmd_i == DSS_CMD_SHUTDOWN && volt_ok) begin
               next_state = DSS_ST_READY; // RULE5
            end
         end
         DSS_ST_READY: begin
            if (!volt_ok || (cmd_ok && (cmd_i == DSS_CMD_DIS_VOLT ||
                cmd_i == DSS_CMD_QSTOP))) begin
               next_state = DSS_ST_SW_DIS;
            end else if (cmd_ok && cmd_i == DSS_CMD_SWITCH_ON) begin
               next_state = DSS_ST_SWITCHED_ON;
            end
         end
         DSS_ST_SWITCHED_ON: begin
            if (cmd_ok && (cmd_i == DSS_CMD_DIS_VOLT ||
                cmd_i == DSS_CMD_QSTOP)) begin
               next_state = DSS_ST_SW_DIS;
            end else if (cmd_ok && cmd_i == DSS_CMD_SHUTDOWN) begin
               next_state = DSS_ST_READY;
            end else if (cmd_ok && cmd_i == DSS_CMD_EN_OP) begin
               next_state = DSS_ST_OP_EN;
            end
         end
         DSS_ST_OP_EN: begin
            if (err_qstop || (cmd_ok && cmd_i == DSS_CMD_QSTOP)) begin
               next_state = DSS_ST_QSTOP;
            end else if (cmd_ok && cmd_i == DSS_CMD_DIS_VOLT) begin
               next_state = DSS_ST_SW_DIS;
            end else if (cmd_ok && cmd_i == DSS_CMD_SHUTDOWN) begin
               next_state = DSS_ST_READY;
            end else if (cmd_ok && cmd_i == DSS_CMD_DIS_OP) begin
               next_state = DSS_ST_SWITCHED_ON;
            end
         end
         DSS_ST_QSTOP: begin
            if (cmd_ok && cmd_i == DSS_CMD_DIS_VOLT) begin
               next_state = DSS_ST_SW_DIS;
            end else if (fault_reset_i) begin
               next_state = DSS_ST_OP_EN;
            end
         end
         DSS_ST_FAULT_REACT: begin
            if (err_resp_done_i) begin
               next_state = DSS_ST_FAULT; // RULE21
            end
         end
         DSS_ST_FAULT: begin
            if (fault_reset_i && cause_cleared_i) begin
               next_state = DSS_ST_SW_DIS; // RULE22
            end
         end
         default: begin
            next_state = DSS_ST_NOT_READY;
         end
      endcase
      // a class 2..7 error wins over anything outside the fault path
      if (err_fault && state != DSS_ST_FAULT_REACT &&
          state != DSS_ST_FAULT) begin
         next_state = DSS_ST_FAULT_REACT;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         state <= DSS_ST_NOT_READY;
      end else begin
         state <= next_state;
      end
   end

   // warning hold timer gets the fault reset as an override
   assign wif.warn_present = (active_warning_register_i != 16'h0000);
   assign wif.fault_reset = fault_reset_i;

   dss_warn_hold #(
      .HOLD_CYC(WARN_HOLD_CYC)
   ) u_warn (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n),
      .wif(wif)
   );

   // operating mode tracking; halt or error ends the run early
   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         op_running <= 1'b0;
         op_good <= 1'b0;
      end else if (op_start_i) begin
         op_running <= 1'b1;
         op_good <= 1'b0;
      end else if (op_done_ok_i) begin
         op_running <= 1'b0;
         op_good <= 1'b1;
      end else if (halt_i || err_valid_i) begin
         op_running <= 1'b0;
         op_good <= 1'b0; // RULE13
      end
   end

   // target reached needs good end plus standstill
   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         target <= 1'b0;
      end else if (op_start_i || !standstill_i || halt_i ||
                   err_valid_i) begin
         target <= 1'b0; // RULE13
      end else if (op_good && !op_running) begin
         target <= 1'b1; // RULE12
      end
   end

   // end flag: a start in the same cycle keeps it low, so
   // back-to-back runs never show a rising edge in between
   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         x_end <= 1'b0;
      end else if (op_start_i) begin
         x_end <= 1'b0; // RULE16 RULE18
      end else if (!op_running && standstill_i) begin
         x_end <= 1'b1; // RULE17
      end
   end

   // error flag; a new error wins over a simultaneous fault reset
   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         x_err <= 1'b0;
      end else if (err_valid_i) begin
         x_err <= 1'b1; // RULE15
      end else if (fault_reset_i && (state != DSS_ST_FAULT_REACT) &&
                   (state != DSS_ST_FAULT || cause_cleared_i)) begin
         x_err <= 1'b0;
      end
   end

   // reference: no power stage term here, so disabling keeps it
   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         ref_ok <= 1'b0;
      end else if (ref_set_i) begin
         ref_ok <= 1'b1; // RULE19 RULE20
      end else if (ref_lost_i) begin
         ref_ok <= 1'b0;
      end
   end

   // plain level flags sampled each cycle
   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         halt_q <= 1'b0;
         remote_q <= 1'b0;
         mode_q <= 1'b0;
      end else begin
         halt_q <= halt_i; // RULE9
         remote_q <= remote_i; // RULE10
         mode_q <= mode_bit_i; // RULE14
      end
   end

   // status word assembly; don't-care bits are driven as zero
   always_comb begin
      next_status = 16'h0000; // RULE23
      unique case (state)
         DSS_ST_NOT_READY: begin
            next_status[6:0] = 7'h00; // RULE2
         end
         DSS_ST_SW_DIS: begin
            next_status[DSS_B_SW_DISABLE] = 1'b1; // RULE2
         end
         DSS_ST_READY: begin
            next_status[DSS_B_QSTOP] = 1'b1; // RULE2
            next_status[DSS_B_READY] = 1'b1;
         end
         DSS_ST_SWITCHED_ON: begin
            next_status[DSS_B_QSTOP] = 1'b1; // RULE2
            next_status[DSS_B_SWITCHED_ON] = 1'b1;
            next_status[DSS_B_READY] = 1'b1;
         end
         DSS_ST_OP_EN: begin
            next_status[DSS_B_QSTOP] = 1'b1; // RULE3
            next_status[2:0] = 3'h7;
         end
         DSS_ST_QSTOP: begin
            next_status[2:0] = 3'h7; // RULE3
         end
         DSS_ST_FAULT_REACT, DSS_ST_FAULT: begin
            next_status[3:0] = 4'hF; // RULE3
         end
         default: begin
            next_status[6:0] = 7'h00;
         end
      endcase
      next_status[DSS_B_VOLT] = volt_ok; // RULE4
      next_status[DSS_B_WARN] = wif.warn_bit; // RULE6
      next_status[DSS_B_HALT] = halt_q; // RULE9
      next_status[DSS_B_REMOTE] = remote_q; // RULE10
      next_status[DSS_B_TARGET] = target; // RULE12
      next_status[DSS_B_RSVD] = 1'b0; // RULE23
      next_status[DSS_B_MODE] = mode_q; // RULE14
      next_status[DSS_B_XERR] = x_err; // RULE15
      next_status[DSS_B_XEND] = x_end; // RULE17
      next_status[DSS_B_REFOK] = ref_ok; // RULE19
   end

   // status word and signal outputs refreshed every clock
   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         status <= DSS_STATUS_RESET;
         no_fault_o <= 1'b0;
         active_o <= 1'b0;
      end else begin
         status <= next_status; // RULE23
         no_fault_o <= sig_out_cfg_i && (state == DSS_ST_READY ||
            state == DSS_ST_SWITCHED_ON || state == DSS_ST_OP_EN); // RULE1
         active_o <= sig_out_cfg_i && (state == DSS_ST_OP_EN); // RULE1
      end
   end

   assign drive_state_status_word_o = status;

   // parameter port: answered whatever the remote bit says
   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         param_rdata_o <= 16'h0000;
         param_ack_o <= 1'b0;
         param_err_o <= 1'b0;
      end else begin
         param_ack_o <= param_rd_i || param_wr_i; // RULE11
         param_err_o <= param_wr_i ||
            (param_rd_i && param_addr_i != DSS_STATUS_ADDR);
         if (param_rd_i && param_addr_i == DSS_STATUS_ADDR) begin
            param_rdata_o <= status; // RULE11
         end else if (param_rd_i) begin
            param_rdata_o <= 16'h0000; // unmapped reads as zero
         end
      end
   end
endmodule

// [sim/dss_status_sva.sv]
// port assertions for the drive state status word block
`timescale 1ns/1ns
module dss_status_sva #(
   parameter int WARN_HOLD_CYC = dss_pkg::DSS_WARN_HOLD_CYC
) (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic sig_out_cfg_i,
   input wire logic halt_i,
   input wire logic remote_i,
   input wire logic fault_reset_i,
   input wire logic ref_set_i,
   input wire logic [15:0] active_warning_register_i,
   input wire logic param_rd_i,
   input wire logic param_wr_i,
   input wire logic [15:0] param_addr_i,
   input wire logic [15:0] param_rdata_o,
   input wire logic param_ack_o,
   input wire logic param_err_o,
   input wire logic [15:0] drive_state_status_word_o,
   input wire logic no_fault_o,
   input wire logic active_o
);
   import dss_pkg::*;
   logic [15:0] sw;
   logic [6:0] sb;
   int unsigned hi_cnt;
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!rst_n_i);
   // state bits with the voltage flag masked out
   assign sw = drive_state_status_word_o;
   assign sb = sw[6:0] & 7'h6F;
   // length of the current high run of the warning bit
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         hi_cnt <= 0;
      end else if (sw[DSS_B_WARN]) begin
         hi_cnt <= hi_cnt + 1;
      end else begin
         hi_cnt <= 0;
      end
   end
   property p_nofault;
      sig_out_cfg_i && $past(sig_out_cfg_i) |->
         no_fault_o == (sb inside {7'h21, 7'h23, 7'h27});
   endproperty
   a_nofault: assert property (p_nofault)
      else $error("no fault output disagrees with state bits");
   property p_active;
      sig_out_cfg_i && $past(sig_out_cfg_i) |-> active_o == (sb == 7'h27);
   endproperty
   a_active: assert property (p_active)
      else $error("active output disagrees with state bits");
   property p_rsvd;
      !sw[DSS_B_RSVD];
   endproperty
   a_rsvd: assert property (p_rsvd)
      else $error("reserved status bit set");
   property p_halt;
      sw[DSS_B_HALT] == $past(halt_i, 2);
   endproperty
   a_halt: assert property (p_halt)
      else $error("halt bit does not follow halt request");
   property p_remote;
      sw[DSS_B_REMOTE] == $past(remote_i, 2);
   endproperty
   a_remote: assert property (p_remote)
      else $error("remote bit does not follow control source");
   property p_ref;
      ref_set_i |-> ##2 sw[DSS_B_REFOK];
   endproperty
   a_ref: assert property (p_ref)
      else $error("reference bit missing after reference set");
   property p_warn_set;
      (|active_warning_register_i) && !fault_reset_i |-> ##2 sw[DSS_B_WARN];
   endproperty
   a_warn_set: assert property (p_warn_set)
      else $error("warning bit missing while warning active");
   // a fault reset two edges back excuses an early fall
   property p_warn_hold;
      $fell(sw[DSS_B_WARN]) |->
         hi_cnt >= WARN_HOLD_CYC || $past(fault_reset_i, 2);
   endproperty
   a_warn_hold: assert property (p_warn_hold)
      else $error("warning bit fell before minimum hold");
   property p_frst;
      fault_reset_i |-> ##2 !sw[DSS_B_WARN];
   endproperty
   a_frst: assert property (p_frst)
      else $error("fault reset did not clear warning bit");
   sequence s_rd_good;
      param_rd_i && !param_wr_i && param_addr_i == DSS_STATUS_ADDR;
   endsequence
   sequence s_rd_bad;
      param_rd_i && !param_wr_i && param_addr_i != DSS_STATUS_ADDR;
   endsequence
   property p_rd;
      logic [15:0] v;
      (s_rd_good, v = sw) |=> param_ack_o && !param_err_o && param_rdata_o == v;
   endproperty
   a_rd: assert property (p_rd)
      else $error("status read returned wrong answer");
   property p_rd_bad;
      s_rd_bad |=> param_ack_o && param_err_o && param_rdata_o == 16'h0000;
   endproperty
   a_rd_bad: assert property (p_rd_bad)
      else $error("unmapped read not refused");
   property p_wr;
      param_wr_i |=> param_err_o;
   endproperty
   a_wr: assert property (p_wr)
      else $error("write to read only word not refused");
endmodule

bind dss_status_top dss_status_sva #(
   .WARN_HOLD_CYC(WARN_HOLD_CYC)
) chk_u (
   .clk_sys_i, .rst_n_i, .sig_out_cfg_i, .halt_i, .remote_i,
   .fault_reset_i, .ref_set_i, .active_warning_register_i, .param_rd_i,
   .param_wr_i, .param_addr_i, .param_rdata_o, .param_ack_o, .param_err_o,
   .drive_state_status_word_o, .no_fault_o, .active_o
);

// [sim/dss_fb_master.sv]
// fieldbus master model that polls the status word parameter
`timescale 1ns/1ns
module dss_fb_master (
   input wire logic clk_sys_i,
   input wire logic [15:0] param_rdata_i,
   input wire logic param_ack_i,
   input wire logic param_err_i,
   output logic param_rd_o = 1'b0,
   output logic param_wr_o = 1'b0,
   output logic [15:0] param_addr_o = 16'h0000
);
   // one access: strobe for one edge, then wait a bounded time for ack
   task automatic acc(input logic w, input logic [15:0] a,
         output logic [15:0] d, output logic er, output logic to);
      @(posedge clk_sys_i);
      param_rd_o <= !w;
      param_wr_o <= w;
      param_addr_o <= a;
      @(posedge clk_sys_i);
      param_rd_o <= 1'b0;
      param_wr_o <= 1'b0;
      // released address flips so a stale value cannot look valid
      param_addr_o <= ~a;
      to = 1'b1;
      // ack stands only from the edge after the strobe to the next one
      for (int n = 0; n < 4 && to; n++) begin
         #1;
         if (param_ack_i === 1'b1 || param_err_i === 1'b1) begin
            to = 1'b0;
         end else begin
            @(posedge clk_sys_i);
         end
      end
      d = param_rdata_i;
      er = param_err_i;
   endtask
endmodule

// [sim/drive_state_status_word_tb.sv]
// self-checking bench for the drive state status word block
`timescale 1ns/1ns
`define CHK(g, e) begin \
   compares++; \
   if ((g) !== (e)) begin \
      bad_count++; \
      $display("unexpected at %0t: got %h want %h", $time, g, e); \
   end \
end
module drive_state_status_word_tb;
   import dss_pkg::*;
   localparam int HOLD = 20;
   int bad_count = 0;
   int compares = 0;
   logic clk_sys_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic dc_ok = 1'b0, init = 1'b0, fb = 1'b0, rem = 1'b0, cc = 1'b0;
   logic halt = 1'b0, still = 1'b0, mode = 1'b0, cfg = 1'b1;
   logic [2:0] ecl = 3'h0;
   logic [15:0] warn = 16'h0000;
   // pulse strobes: fault reset, error, response done, start, done, ref, cmd
   logic [6:0] pl = 7'h00;
   dss_cmd_t cmd = DSS_CMD_SHUTDOWN;
   logic rd, wr, ack, err, nf, act, er, to;
   logic [15:0] addr, rdata, sw, d;
   always #10 clk_sys_i = ~clk_sys_i;
   // state indication on the signal outputs is switched off once
   dss_status_top #(.WARN_HOLD_CYC(HOLD)) dut_u (
      .clk_sys_i, .rst_n_i, .dc_bus_ok_i(dc_ok), .init_done_i(init),
      .cmd_valid_i(pl[6]), .cmd_i(cmd), .cmd_from_fb_i(fb), .remote_i(rem),
      .fault_reset_i(pl[0]), .cause_cleared_i(cc), .err_valid_i(pl[1]),
      .err_class_i(ecl), .err_resp_done_i(pl[2]),
      .active_warning_register_i(warn), .halt_i(halt), .op_start_i(pl[3]),
      .op_done_ok_i(pl[4]), .standstill_i(still), .mode_bit_i(mode),
      .ref_set_i(pl[5]), .ref_lost_i(1'b0), .sig_out_cfg_i(cfg),
      .param_rd_i(rd), .param_wr_i(wr), .param_addr_i(addr),
      .param_rdata_o(rdata), .param_ack_o(ack), .param_err_o(err),
      .drive_state_status_word_o(sw), .no_fault_o(nf), .active_o(act)
   );
   dss_fb_master fbm_u (
      .clk_sys_i, .param_rdata_i(rdata), .param_ack_i(ack),
      .param_err_i(err), .param_rd_o(rd), .param_wr_o(wr),
      .param_addr_o(addr)
   );
   task automatic wrap_up;
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // one-cycle strobes; several bits at once model simultaneous events
   task automatic pulse(input logic [6:0] m,
         input dss_cmd_t c = DSS_CMD_SHUTDOWN, input logic f = 1'b0);
      @(posedge clk_sys_i);
      pl <= m;
      cmd <= c;
      fb <= f;
      @(posedge clk_sys_i);
      pl <= 7'h00;
   endtask
   // let status settle, then compare port and fieldbus read
   task automatic st(input logic [15:0] e, input logic [1:0] o = 2'b00);
      repeat (4) @(posedge clk_sys_i);
      #1;
      `CHK(sw, e)
      `CHK({nf, act}, o)
      fbm_u.acc(1'b0, DSS_STATUS_ADDR, d, er, to);
      `CHK({d, er, to}, {e, 2'b00})
   endtask
   initial begin
      repeat (2) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      st(16'h0000);
      @(posedge clk_sys_i);
      init <= 1'b1;
      st(16'h0040);
      pulse(7'h40, DSS_CMD_SHUTDOWN);
      st(16'h0040);
      @(posedge clk_sys_i);
      dc_ok <= 1'b1;
      st(16'h0050);
      pulse(7'h40, DSS_CMD_SHUTDOWN);
      st(16'h0031, 2'b10);
      pulse(7'h40, DSS_CMD_SWITCH_ON);
      st(16'h0033, 2'b10);
      pulse(7'h40, DSS_CMD_EN_OP);
      st(16'h0037, 2'b11);
      @(posedge clk_sys_i);
      cfg <= 1'b0;
      st(16'h0037);
      @(posedge clk_sys_i);
      cfg <= 1'b1;
      pulse(7'h40, DSS_CMD_DIS_OP, 1'b1);
      st(16'h0037, 2'b11);
      @(posedge clk_sys_i);
      rem <= 1'b1;
      halt <= 1'b1;
      mode <= 1'b1;
      st(16'h1337, 2'b11);
      @(posedge clk_sys_i);
      halt <= 1'b0;
      mode <= 1'b0;
      pulse(7'h20);
      st(16'h8237, 2'b11);
      @(posedge clk_sys_i);
      still <= 1'b1;
      st(16'hC237, 2'b11);
      @(posedge clk_sys_i);
      still <= 1'b0;
      pulse(7'h08);
      st(16'h8237, 2'b11);
      // good end, then a new start on the very next cycle
      @(posedge clk_sys_i);
      still <= 1'b1;
      pl <= 7'h10;
      @(posedge clk_sys_i);
      pl <= 7'h08;
      @(posedge clk_sys_i);
      pl <= 7'h00;
      repeat (4) @(posedge clk_sys_i);
      #1;
      `CHK(sw[DSS_B_XEND], 1'b0)
      pulse(7'h10);
      st(16'hC637, 2'b11);
      // short warning must outlast its cause
      @(posedge clk_sys_i);
      warn <= 16'h0004;
      @(posedge clk_sys_i);
      warn <= 16'h0000;
      st(16'hC6B7, 2'b11);
      repeat (8) @(posedge clk_sys_i);
      #1;
      `CHK(sw[DSS_B_WARN], 1'b1)
      repeat (8) @(posedge clk_sys_i);
      st(16'hC637, 2'b11);
      @(posedge clk_sys_i);
      warn <= 16'h0100;
      @(posedge clk_sys_i);
      warn <= 16'h0000;
      pulse(7'h01);
      st(16'hC637, 2'b11);
      @(posedge clk_sys_i);
      ecl <= DSS_ERR_CLASS_QS;
      pulse(7'h02);
      st(16'hE217);
      pulse(7'h01);
      st(16'hC237, 2'b11);
      pulse(7'h40, DSS_CMD_QSTOP);
      st(16'hC217);
      pulse(7'h40, DSS_CMD_DIS_VOLT);
      st(16'hC250);
      @(posedge clk_sys_i);
      ecl <= 3'h2;
      pulse(7'h02);
      st(16'hE21F);
      pulse(7'h01);
      st(16'hE21F);
      pulse(7'h04);
      pulse(7'h01);
      st(16'hE21F);
      @(posedge clk_sys_i);
      cc <= 1'b1;
      pulse(7'h01);
      st(16'hC250);
      fbm_u.acc(1'b1, DSS_STATUS_ADDR, d, er, to);
      `CHK({er, to}, 2'b10)
      fbm_u.acc(1'b0, 16'h1B06, d, er, to);
      `CHK({d, er, to}, {16'h0000, 2'b10})
      wrap_up();
   end
endmodule
